// [src/dbgx_pkg.sv]
package dbgx_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int NPROC = 2;
	localparam int PTRIG_N = 8;
	localparam int ETRIG_N = 4;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_KEY = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_PSEL = 8'h10;
	localparam logic [7:0] OFS_PXCTL = 8'h14;
	localparam logic [7:0] OFS_EXCTL = 8'h18;
	localparam logic [7:0] OFS_TSTAT = 8'h1c;

	// unlock key, value arbitrary
	localparam logic [31:0] UNLOCK_KEY = 32'h6b65_7931;

	// ****************************************************************
	// access control word fields
	// ****************************************************************
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_CMD_W = 8;
	localparam int CTRL_TGT_BIT = 8;
	localparam int CTRL_LOCK_LSB = 9;
	localparam int CTRL_SIZE_LSB = 11;
	localparam int CTRL_SIZE_W = 8;
	localparam logic [1:0] LOCK_NONE = 2'b00;
	localparam logic [1:0] LOCK_ONCE = 2'b01;
	localparam logic [1:0] LOCK_KEEP = 2'b10;

	// access status bits
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_JTAG_BIT = 1;
	localparam int STAT_OPEN_BIT = 2;
	localparam int STAT_WORDS_LSB = 4;

	// ****************************************************************
	// cross trigger control words
	// ****************************************************************
	localparam int PX_SRC_LSB = 12;
	localparam int PX_MASK_LSB = 4;
	localparam int PX_AND_BIT = 3;
	localparam int PX_IDX_LSB = 0;
	localparam int EX_SRC_LSB = 6;
	localparam int EX_MASK_LSB = 2;
	localparam int EX_IDX_LSB = 0;
	localparam int PSEL_W = 8;

	// source codes
	localparam logic [3:0] SRC_ONE = 4'h0;
	localparam logic [3:0] SRC_PIN0 = 4'h1;
	localparam logic [3:0] SRC_PIN7 = 4'h8;
	localparam logic [3:0] SRC_EIN0 = 4'h9;
	localparam logic [3:0] SRC_EIN3 = 4'hc;
	localparam logic [3:0] SRC_ZERO = 4'hd;

	// reset values
	localparam logic [7:0] RST_PMASK = 8'hff;
	localparam logic [3:0] RST_EMASK = 4'hf;

	typedef enum logic [1:0] {
		DBGX_IDLE = 2'b00,
		DBGX_WAIT = 2'b01,
		DBGX_DONE = 2'b11
	} dbgx_apb_e;

endpackage

// [src/dbgx_xbar_if.sv]
interface dbgx_xbar_if;
	import dbgx_pkg::*;

	logic px_we;
	logic ex_we;
	logic [15:0] wdata;
	logic [NPROC-1:0] proc_sel;
	logic [NPROC*PTRIG_N-1:0] ptrig_in;
	logic [ETRIG_N-1:0] etrig_in;
	logic [NPROC*PTRIG_N-1:0] ptrig_out;
	logic [ETRIG_N-1:0] etrig_out;

	modport ctl (output px_we, output ex_we, output wdata, output proc_sel,
		output ptrig_in, output etrig_in, input ptrig_out, input etrig_out);
	modport xbar (input px_we, input ex_we, input wdata, input proc_sel,
		input ptrig_in, input etrig_in, output ptrig_out, output etrig_out);
endinterface

// [src/dbgx_xbar.sv]
module dbgx_xbar
	import dbgx_pkg::*;
#(
	parameter bit CROSS_EN = 1'b1,
	parameter int EXT_IN_N = 4,
	parameter int EXT_OUT_N = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration and trigger lines
	dbgx_xbar_if.xbar xb
);

	// ****************************************************************
	// source evaluation
	// ****************************************************************
	function automatic logic src_val(input logic [3:0] code, input logic [7:0] pin,
			input logic [7:0] pmask, input logic and_mode, input logic [3:0] ein,
			input logic [3:0] emask);
		logic [7:0] m;
		logic [2:0] i;
		logic [1:0] j;
		logic v;
		for (int k = 0; k < 8; k++) begin
			m[k] = pmask[7-k];
		end
		i = 3'(code - SRC_PIN0);
		j = 2'(code - SRC_EIN0);
		v = 1'b0;
		if (code == SRC_ONE) begin
			v = 1'b1;
		end else if (code >= SRC_PIN0 && code <= SRC_PIN7) begin
			v = and_mode ? (pin[i] & (&(pin | ~m))) : (pin[i] & m[i]);
		end else if (code >= SRC_EIN0 && code <= SRC_EIN3) begin
			v = ein[j] & emask[3-j];
		end
		return v;
	endfunction

	// ****************************************************************
	// per processor, per output settings, and per external output settings
	// ****************************************************************
	logic [3:0] psrc_ff [NPROC][PTRIG_N];
	logic [7:0] pmask_ff [NPROC][PTRIG_N];
	logic pand_ff [NPROC][PTRIG_N];
	logic [3:0] esrc_ff [ETRIG_N];
	logic [3:0] emask_ff [ETRIG_N];
	logic [ETRIG_N-1:0] ein_en;
	logic [PTRIG_N-1:0] pin_any;

	always_comb begin
		for (int k = 0; k < ETRIG_N; k++) begin
			ein_en[k] = CROSS_EN && (k < EXT_IN_N);
		end
		pin_any = '0;
		for (int p = 0; p < NPROC; p++) begin
			pin_any = pin_any | xb.ptrig_in[p*PTRIG_N +: PTRIG_N];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < NPROC; p++) begin
				for (int o = 0; o < PTRIG_N; o++) begin
					psrc_ff[p][o] <= (o < ETRIG_N) ? 4'(SRC_EIN0 + o) : SRC_ZERO;
					pmask_ff[p][o] <= RST_PMASK;
					pand_ff[p][o] <= 1'b0;
				end
			end
		end else if (xb.px_we) begin
			for (int p = 0; p < NPROC; p++) begin
				if (xb.proc_sel[p]) begin
					psrc_ff[p][xb.wdata[PX_IDX_LSB +: 3]] <= xb.wdata[PX_SRC_LSB +: 4];
					pmask_ff[p][xb.wdata[PX_IDX_LSB +: 3]] <= xb.wdata[PX_MASK_LSB +: 8];
					pand_ff[p][xb.wdata[PX_IDX_LSB +: 3]] <= xb.wdata[PX_AND_BIT];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int o = 0; o < ETRIG_N; o++) begin
				esrc_ff[o] <= 4'(SRC_PIN0 + o);
				emask_ff[o] <= RST_EMASK;
			end
		end else if (xb.ex_we) begin
			esrc_ff[xb.wdata[EX_IDX_LSB +: 2]] <= xb.wdata[EX_SRC_LSB +: 4];
			emask_ff[xb.wdata[EX_IDX_LSB +: 2]] <= xb.wdata[EX_MASK_LSB +: 4];
		end
	end

	// ****************************************************************
	// registered trigger outputs
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xb.ptrig_out <= '0;
			xb.etrig_out <= '0;
		end else begin
			for (int p = 0; p < NPROC; p++) begin
				for (int o = 0; o < PTRIG_N; o++) begin
					xb.ptrig_out[p*PTRIG_N+o] <= CROSS_EN && src_val(psrc_ff[p][o],
						xb.ptrig_in[p*PTRIG_N +: PTRIG_N], pmask_ff[p][o], pand_ff[p][o],
						xb.etrig_in & ein_en, RST_EMASK);
				end
			end
			for (int o = 0; o < ETRIG_N; o++) begin
				xb.etrig_out[o] <= CROSS_EN && (o < EXT_OUT_N) && src_val(esrc_ff[o],
					pin_any, RST_PMASK, 1'b0, xb.etrig_in & ein_en, emask_ff[o]);
			end
		end
	end

endmodule // dbgx_xbar

// [src/dbgx_top.sv]
// Overview of operation
// - control and data registers stay closed until the key register gets the key.
// - any other value written to the key register closes them again.
// - control write sets size in bits, 8-bit command, target kind and lock type.
// - lock type 01 locks before first data word, unlocks after the last.
// - lock type 10 locks before first data word and keeps holding.
// - writing lock type 00 releases a held lock, aborting a sequence.
// - status shows lock acquired; software rereads and retries control if not.
// - data moves in 32-bit words, one per started 32 bits of size.
// - while the lock is held the JTAG side is denied the debug registers.
// - crossbar routes own processor and external inputs to processor outputs, ORed processor inputs and external inputs to external outputs.
// - after reset processor inputs 0-3 drive external outputs 0-3.
// - after reset external inputs 0-3 drive processor outputs 0-3.
// - settings held per output and processor; write hits all selected processors.
// - processor control write programs the output named by its index.
// - external control write programs the external output named by its index.
// - number of external trigger inputs and outputs set by build parameters.
// - source code 0 one, 1-8 processor inputs, 9-12 external, 13 zero.
// - processor word: source 15-12, mask 11-4, and/or bit 3, index 2-0.
// - external word: source 9-6, mask 5-2 reset ones, index 1-0.
//
// Implementation choices: the register addresses and the APB interface to the registers.
module dbgx_top
	import dbgx_pkg::*;
#(
	parameter bit CROSS_EN = 1'b1,
	parameter int EXT_IN_N = 4,
	parameter int EXT_OUT_N = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// debug register path
	output logic dbg_req,
	output logic dbg_we,
	output logic [7:0] dbg_cmd,
	output logic dbg_tgt_proc,
	output logic [NPROC-1:0] dbg_proc_sel,
	output logic [31:0] dbg_wdata,
	input wire logic [31:0] dbg_rdata,
	input wire logic dbg_ack,
	// jtag side arbitration
	input wire logic jtag_busy,
	output logic jtag_deny,
	// trigger lines
	input wire logic [NPROC*PTRIG_N-1:0] ptrig_in,
	output logic [NPROC*PTRIG_N-1:0] ptrig_out,
	input wire logic [ETRIG_N-1:0] etrig_in,
	output logic [ETRIG_N-1:0] etrig_out
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int k = 0; k < 8; k++) begin
			r[k] = v[7-k];
		end
		return r;
	endfunction

	function automatic logic [3:0] rev4(input logic [3:0] v);
		return {v[0], v[1], v[2], v[3]};
	endfunction

	// words needed for a size in bits held as size minus one
	function automatic logic [3:0] words_of(input logic [CTRL_SIZE_W-1:0] size_m1);
		return {1'b0, size_m1[7:5]} + 4'h1;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	dbgx_apb_e st_ff;
	logic open_ff;
	logic [31:0] ctrl_ff;
	logic lock_ff;
	logic [1:0] ltype_ff;
	logic [3:0] words_ff;
	logic [PSEL_W-1:0] psel_reg_ff;
	logic [NPROC-1:0] proc_sel;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic dbg_req_ff;
	logic dbg_we_ff;
	logic [31:0] dbg_wdata_ff;
	logic [NPROC-1:0] dbg_proc_sel_ff;
	logic jtag_deny_ff;

	logic acc;
	logic wr;
	logic mapped;
	logic is_key;
	logic is_ctrl;
	logic is_data;
	logic data_ok;
	logic ctrl_wr;
	logic data_done;
	logic [1:0] req_lock;
	logic [31:0] stat_word;
	logic [31:0] tstat_word;
	logic [31:0] nxt_rdata;

	dbgx_xbar_if xb ();

	// processor select, bit 7 is processor 0
	always_comb begin
		for (int p = 0; p < NPROC; p++) begin
			proc_sel[p] = psel_reg_ff[PSEL_W-1-p];
		end
	end

	// ****************************************************************
	// decode
	// ****************************************************************
	assign acc = psel && penable && (st_ff != DBGX_DONE);
	assign wr = pwrite;
	assign is_key = paddr == OFS_KEY;
	assign is_ctrl = paddr == OFS_CTRL;
	assign is_data = paddr == OFS_DATA;
	assign mapped = is_key || is_ctrl || is_data || (paddr == OFS_STAT) || (paddr == OFS_PSEL)
		|| (paddr == OFS_PXCTL) || (paddr == OFS_EXCTL) || (paddr == OFS_TSTAT);
	assign data_ok = open_ff && lock_ff && (words_ff != 4'h0);
	assign ctrl_wr = acc && wr && is_ctrl && open_ff && (st_ff == DBGX_IDLE);
	assign data_done = (st_ff == DBGX_WAIT) && dbg_ack;
	assign req_lock = pwdata[CTRL_LOCK_LSB +: 2];

	always_comb begin
		stat_word = '0;
		stat_word[STAT_LOCK_BIT] = lock_ff;
		stat_word[STAT_JTAG_BIT] = jtag_busy;
		stat_word[STAT_OPEN_BIT] = open_ff;
		stat_word[STAT_WORDS_LSB +: 4] = words_ff;
	end

	// trigger status of the lowest selected processor
	always_comb begin
		tstat_word = '0;
		for (int p = NPROC - 1; p >= 0; p--) begin
			if (proc_sel[p]) begin
				tstat_word[23:16] = rev8(xb.ptrig_out[p*PTRIG_N +: PTRIG_N]);
				tstat_word[15:8] = rev8(ptrig_in[p*PTRIG_N +: PTRIG_N]);
			end
		end
		tstat_word[7:4] = rev4(xb.etrig_out);
		tstat_word[3:0] = rev4(etrig_in);
	end

	always_comb begin
		nxt_rdata = '0;
		case (paddr)
			OFS_CTRL: nxt_rdata = open_ff ? ctrl_ff : 32'h0000_0000;
			OFS_STAT: nxt_rdata = stat_word;
			OFS_PSEL: nxt_rdata = {24'h00_0000, psel_reg_ff};
			OFS_TSTAT: nxt_rdata = tstat_word;
			default: nxt_rdata = '0;
		endcase
	end

	// ****************************************************************
	// apb handshake
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= DBGX_IDLE;
		end else begin
			case (st_ff)
				DBGX_IDLE: begin
					if (acc && is_data && data_ok) begin
						st_ff <= DBGX_WAIT;
					end else if (acc) begin
						st_ff <= DBGX_DONE;
					end
				end
				DBGX_WAIT: begin
					if (dbg_ack) begin
						st_ff <= DBGX_DONE;
					end
				end
				DBGX_DONE: st_ff <= DBGX_IDLE;
				default: st_ff <= DBGX_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			if (data_done) begin
				pready_ff <= 1'b1;
				prdata_ff <= dbg_we_ff ? 32'h0000_0000 : dbg_rdata;
			end else if (acc && st_ff == DBGX_IDLE && !(is_data && data_ok)) begin
				pready_ff <= 1'b1;
				pslverr_ff <= !mapped;
				prdata_ff <= wr ? 32'h0000_0000 : nxt_rdata;
			end
		end
	end

	// ****************************************************************
	// key register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_ff <= 1'b0;
		end else if (acc && wr && is_key && st_ff == DBGX_IDLE) begin
			open_ff <= pwdata == UNLOCK_KEY;
		end
	end

	// ****************************************************************
	// access control and lock
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= '0;
		end else if (ctrl_wr) begin
			ctrl_ff <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_ff <= 1'b0;
			ltype_ff <= LOCK_NONE;
			words_ff <= 4'h0;
		end else if (ctrl_wr) begin
			ltype_ff <= req_lock;
			if (req_lock == LOCK_NONE || req_lock == 2'b11) begin
				lock_ff <= 1'b0;
				words_ff <= 4'h0;
			end else if (lock_ff || !jtag_busy) begin
				lock_ff <= 1'b1;
				words_ff <= words_of(pwdata[CTRL_SIZE_LSB +: CTRL_SIZE_W]);
			end else begin
				lock_ff <= 1'b0;
				words_ff <= 4'h0;
			end
		end else if (data_done) begin
			words_ff <= words_ff - 4'h1;
			if (words_ff == 4'h1 && ltype_ff == LOCK_ONCE) begin
				lock_ff <= 1'b0;
			end
		end
	end

	// jtag side locked out while lock is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			jtag_deny_ff <= 1'b0;
		end else begin
			jtag_deny_ff <= lock_ff || (ctrl_wr && req_lock != LOCK_NONE && req_lock != 2'b11
				&& !jtag_busy);
		end
	end

	// ****************************************************************
	// debug data requests
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_req_ff <= 1'b0;
			dbg_we_ff <= 1'b0;
			dbg_wdata_ff <= '0;
			dbg_proc_sel_ff <= '0;
		end else begin
			dbg_req_ff <= 1'b0;
			if (acc && st_ff == DBGX_IDLE && is_data && data_ok) begin
				dbg_req_ff <= 1'b1;
				dbg_we_ff <= wr;
				dbg_wdata_ff <= wr ? pwdata : 32'h0000_0000;
				dbg_proc_sel_ff <= proc_sel;
			end
		end
	end

	// ****************************************************************
	// processor select register
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psel_reg_ff <= '0;
		end else if (acc && wr && paddr == OFS_PSEL && st_ff == DBGX_IDLE) begin
			psel_reg_ff <= pwdata[PSEL_W-1:0];
		end
	end

	// ****************************************************************
	// cross trigger crossbar
	// ****************************************************************
	assign xb.px_we = acc && wr && paddr == OFS_PXCTL && st_ff == DBGX_IDLE;
	assign xb.ex_we = acc && wr && paddr == OFS_EXCTL && st_ff == DBGX_IDLE;
	assign xb.wdata = pwdata[15:0];
	assign xb.proc_sel = proc_sel;
	assign xb.ptrig_in = ptrig_in;
	assign xb.etrig_in = etrig_in;

	dbgx_xbar #(
		.CROSS_EN(CROSS_EN),
		.EXT_IN_N(EXT_IN_N),
		.EXT_OUT_N(EXT_OUT_N)
	) u_xbar (
		.pclk(pclk),
		.presetn(presetn),
		.xb(xb.xbar)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign dbg_req = dbg_req_ff;
	assign dbg_we = dbg_we_ff;
	assign dbg_cmd = ctrl_ff[CTRL_CMD_LSB +: CTRL_CMD_W];
	assign dbg_tgt_proc = ctrl_ff[CTRL_TGT_BIT];
	assign dbg_proc_sel = dbg_proc_sel_ff;
	assign dbg_wdata = dbg_wdata_ff;
	assign jtag_deny = jtag_deny_ff;
	assign ptrig_out = xb.ptrig_out;
	assign etrig_out = xb.etrig_out;

endmodule // dbgx_top

// [dv/dbgx_top_sva.sv]
module dbgx_top_sva
	import dbgx_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// debug path
	input wire logic dbg_req,
	input wire logic dbg_ack,
	input wire logic jtag_deny
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************************************
	// bus answer
	// ****************************************************************
	sequence s_word_wait;
		psel && penable && paddr == OFS_DATA && dbg_ack && !pready;
	endsequence

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_needs_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_quick_answer: assert property (
		psel && $rose(penable) && paddr != OFS_DATA |=> pready)
		else $error("register access not answered next cycle");
	a_err_unmapped: assert property (
		pready && paddr[7:5] != 3'b000 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access without error");

	// ****************************************************************
	// debug words
	// ****************************************************************
	a_req_pulse: assert property (dbg_req |=> !dbg_req)
		else $error("word request longer than one cycle");
	a_req_in_data: assert property (
		dbg_req |-> psel && penable && paddr == OFS_DATA && !pready)
		else $error("word request outside data access");
	a_req_has_lock: assert property (dbg_req |-> jtag_deny)
		else $error("word moved while jtag not denied");
	a_ack_to_ready: assert property (s_word_wait |=> pready)
		else $error("no pready after word ack");
endmodule // dbgx_top_sva

bind dbgx_top dbgx_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .dbg_req(dbg_req), .dbg_ack(dbg_ack), .jtag_deny(jtag_deny));

// [dv/dbgx_dbg_model.sv]
module dbgx_dbg_model #(
	parameter logic [31:0] RD_BASE = 32'h5eed_0000
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// word request
	input wire logic dbg_req,
	input wire logic slow,
	output logic dbg_ack,
	output logic [31:0] dbg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt_ff;
	logic [31:0] n_ff;

	// read word only valid with ack, churns otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
			n_ff <= 32'h0;
			dbg_ack <= 1'b0;
			dbg_rdata <= 32'h0;
		end else begin
			dbg_ack <= 1'b0;
			dbg_rdata <= ~dbg_rdata;
			if (dbg_req) begin
				cnt_ff <= slow ? 4'h6 : 4'h1;
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
				if (cnt_ff == 4'h1) begin
					dbg_ack <= 1'b1;
					dbg_rdata <= RD_BASE + n_ff;
					n_ff <= n_ff + 32'h1;
				end
			end
		end
	end
endmodule // dbgx_dbg_model

// [dv/tb_top.sv]
module tb_top;
	import dbgx_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x;
		logic e; logic t; logic [15:0] pt; logic [3:0] et;
	} dbgx_row_s;

	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, dbg_wdata, dbg_rdata, rd;
	logic pready, pslverr, dbg_req, dbg_we, dbg_tgt_proc, dbg_ack, jtag_deny, er;
	logic jtag_busy = 1'b0, slow = 1'b0;
	logic [7:0] dbg_cmd;
	logic [1:0] dbg_proc_sel;
	logic [15:0] ptrig_in = 16'h0205, ptrig_out;
	logic [3:0] etrig_in = 4'ha, etrig_out;
	int err_count = 0;
	int check_count = 0;

	dbgx_row_s rows [21] = '{
		'{OFS_PSEL, 1, 32'h80, 0, 0, 0, 0, 0},
		'{OFS_PXCTL, 1, 32'h0ff5, 0, 0, 1, 16'h0a2a, 4'h7},
		'{OFS_PXCTL, 1, 32'hdff5, 0, 0, 1, 16'h0a0a, 4'h7},
		'{OFS_PSEL, 1, 32'hc0, 0, 0, 0, 0, 0},
		'{OFS_PXCTL, 1, 32'haff7, 0, 0, 1, 16'h8a8a, 4'h7},
		'{OFS_PSEL, 1, 32'h80, 0, 0, 0, 0, 0},
		'{OFS_PXCTL, 1, 32'h1c0e, 0, 0, 1, 16'h8a8a, 4'h7},
		'{OFS_PXCTL, 1, 32'h1c06, 0, 0, 1, 16'h8aca, 4'h7},
		'{OFS_EXCTL, 1, 32'h03f, 0, 0, 1, 16'h8aca, 4'hf},
		'{OFS_EXCTL, 1, 32'h37e, 0, 0, 1, 16'h8aca, 4'hb},
		'{OFS_TSTAT, 0, 0, 32'h0053a0d5, 0, 0, 0, 0},
		'{OFS_EXCTL, 1, 32'h2af, 0, 0, 1, 16'h8aca, 4'h3},
		'{OFS_EXCTL, 1, 32'h2bf, 0, 0, 1, 16'h8aca, 4'hb},
		'{OFS_EXCTL, 1, 32'h3bf, 0, 0, 1, 16'h8aca, 4'h3},
		'{OFS_CTRL, 1, 32'h1fb5a, 0, 0, 0, 0, 0},
		'{OFS_CTRL, 0, 0, 32'h0, 0, 0, 0, 0},
		'{OFS_KEY, 1, UNLOCK_KEY, 0, 0, 0, 0, 0},
		'{OFS_CTRL, 1, 32'h1fb5a, 0, 0, 0, 0, 0},
		'{OFS_CTRL, 0, 0, 32'h1fb5a, 0, 0, 0, 0},
		'{OFS_STAT, 0, 0, 32'h25, 0, 0, 0, 0},
		'{8'h20, 0, 0, 32'h0, 1, 0, 0, 0}
	};

	always #2.5 pclk = ~pclk;

	dbgx_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dbg_req(dbg_req), .dbg_we(dbg_we),
		.dbg_cmd(dbg_cmd), .dbg_tgt_proc(dbg_tgt_proc), .dbg_proc_sel(dbg_proc_sel),
		.dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack),
		.jtag_busy(jtag_busy), .jtag_deny(jtag_deny), .ptrig_in(ptrig_in),
		.ptrig_out(ptrig_out), .etrig_in(etrig_in), .etrig_out(etrig_out));

	dbgx_dbg_model u_model (.pclk(pclk), .presetn(presetn), .dbg_req(dbg_req),
		.slow(slow), .dbg_ack(dbg_ack), .dbg_rdata(dbg_rdata));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic wrap_up;
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			wrap_up();
		end
	endtask

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w) chk("rdata", rows[i].x, rd);
			chk("pslverr", 32'(rows[i].e), 32'(er));
			if (rows[i].t) begin
				repeat (2) @(posedge pclk);
				chk("ptrig_out", 32'(rows[i].pt), 32'(ptrig_out));
				chk("etrig_out", 32'(rows[i].et), 32'(etrig_out));
			end
		end
		apb(OFS_DATA, 1'b1, 32'hcafe_0001);
		chk("dbg_wdata", 32'hcafe_0001, dbg_wdata);
		chk("dbg_we", 32'h1, 32'(dbg_we));
		chk("dbg_cmd", 32'h5a, 32'(dbg_cmd));
		chk("dbg_tgt", 32'h1, 32'(dbg_tgt_proc));
		chk("dbg_sel", 32'h1, 32'(dbg_proc_sel));
		slow <= 1'b1;
		apb(OFS_DATA, 1'b0, 32'h0);
		chk("data word", 32'h5eed_0001, rd);
		chk("dbg_we read", 32'h0, 32'(dbg_we));
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat once", 32'h04, rd);
		chk("deny off", 32'h0, 32'(jtag_deny));
		apb(OFS_DATA, 1'b0, 32'h0);
		chk("data closed", 32'h0, rd);
		apb(OFS_CTRL, 1'b1, 32'hfc11);
		apb(OFS_DATA, 1'b1, 32'h1234_5678);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat keep", 32'h05, rd);
		chk("deny on", 32'h1, 32'(jtag_deny));
		apb(OFS_CTRL, 1'b1, 32'h211);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat last", 32'h15, rd);
		apb(OFS_DATA, 1'b0, 32'h0);
		chk("last word", 32'h5eed_0003, rd);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat freed", 32'h04, rd);
		apb(OFS_CTRL, 1'b1, 32'hfc11);
		apb(OFS_CTRL, 1'b1, 32'h611);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat type3", 32'h4, rd & 32'h7);
		apb(OFS_CTRL, 1'b1, 32'hfc11);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat retake", 32'h15, rd);
		apb(OFS_CTRL, 1'b1, 32'h0);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat abort", 32'h4, rd & 32'h7);
		chk("deny off", 32'h0, 32'(jtag_deny));
		jtag_busy <= 1'b1;
		apb(OFS_CTRL, 1'b1, 32'h211);
		apb(OFS_STAT, 1'b0, 32'h0);
		chk("stat busy", 32'h6, rd & 32'h7);
		jtag_busy <= 1'b0;
		apb(OFS_KEY, 1'b1, 32'h0);
		apb(OFS_CTRL, 1'b0, 32'h0);
		chk("ctrl shut", 32'h0, rd);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("ptrig reset", 32'h0a0a, 32'(ptrig_out));
		chk("etrig reset", 32'h7, 32'(etrig_out));
		wrap_up();
	end
endmodule // tb_top
